// >>> core/comparator_control_map.vh
// Register map, field positions, reset values and timing for the comparator control block
`ifndef COMPARATOR_CONTROL_MAP_VH
`define COMPARATOR_CONTROL_MAP_VH

// Printed offsets are not all multiples of four: byte address is four times the index
`define IDX_STATUS_HYST      16'h0094
`define IDX_CFG_AB           16'hA030
`define IDX_CFG_CD           16'hA031
`define IDX_THRESH_FIRST     16'hA032
`define IDX_THRESH_SECOND    16'hA033
`define IDX_IRQ_MASK         16'hA034
`define ADDR_STATUS_HYST     18'h00250
`define ADDR_CFG_AB          18'h280C0
`define ADDR_CFG_CD          18'h280C4
`define ADDR_THRESH_FIRST    18'h280C8
`define ADDR_THRESH_SECOND   18'h280CC
`define ADDR_IRQ_MASK        18'h280D0
`define ADDR_WIDTH           18

// Per-comparator config nibble: enable, threshold choice, irq allow, invert
`define CFG_ON_BIT           3
`define CFG_CHOICE_BIT       2
`define CFG_IRQ_BIT          1
`define CFG_INVERT_BIT       0

// Status register fields
`define ST_FLAG_LSB          4
`define ST_BCD_HYS_LSB       2
`define ST_A_HYS_LSB         0

`define RST_CFG              8'h00
`define RST_THRESH           8'h00
`define RST_HYS              2'h0
`define RST_MASK             4'hF

// Hysteresis codes
`define HYS_NONE             2'h0
`define HYS_10MV             2'h1
`define HYS_20MV             2'h2
`define HYS_30MV             2'h3

// Bias settling time for software, in ns, and cycles at 25 MHz
`define SETTLE_NS            20000
`define CLK_PERIOD_NS        40
`define SETTLE_CYCLES        (`SETTLE_NS / `CLK_PERIOD_NS)

`endif

// >>> core/comparator_channel.v
// One comparator channel: synchroniser, polarity, gating and toggle detection
`timescale 1ns/1ps
module comparator_channel (
    // Clock and reset
    input  wire i_clk,
    input  wire i_rstn,
    // Control and raw analog result
    input  wire i_on,
    input  wire i_invert,
    input  wire i_raw,
    // Results
    output reg  o_live,
    output reg  o_toggle
);
    reg sync_first;
    reg sync_second;
    reg o_live_valid;
    wire gated;

    assign gated = i_on & (sync_second ^ i_invert);

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            sync_first  <= 1'b0;
            sync_second <= 1'b0;
            o_live      <= 1'b0;
            o_toggle    <= 1'b0;
        end else begin
            sync_first  <= i_raw;
            sync_second <= sync_first;
            o_live      <= gated;
            // only while enabled; enabling alone is not an edge
            o_toggle    <= i_on & (gated != o_live) & o_live_valid;
        end
    end

    // Skip the first compare after enable so switching on does not fake an edge
    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_live_valid <= 1'b0;
        end else begin
            o_live_valid <= i_on;
        end
    end
endmodule

// >>> core/analog_comparator_control.v
// APB register block and control logic for four analog comparators
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`include "comparator_control_map.vh"

module analog_comparator_control (
    // Clock and reset
    input  wire        i_clk,
    input  wire        i_rstn,
    // APB slave
    input  wire        i_psel,
    input  wire        i_penable,
    input  wire        i_pwrite,
    input  wire [31:0] i_paddr,
    input  wire [31:0] i_pwdata,
    output reg  [31:0] o_prdata,
    output reg         o_pready,
    output reg         o_pslverr,
    // Raw comparator results, index 0 is A
    input  wire [3:0]  i_cmp_raw,
    // Analog controls
    output reg  [3:0]  o_cmp_on,
    output reg  [3:0]  o_use_alt_threshold,
    output reg  [7:0]  o_first_threshold_level,
    output reg  [7:0]  o_second_threshold_level,
    output reg  [1:0]  o_a_hysteresis_code,
    output reg  [1:0]  o_bcd_hysteresis_code,
    // Interrupt
    output reg         o_irq
);
    reg  [7:0] comparator_ab_config;
    reg  [7:0] comparator_cd_config;
    reg  [3:0] toggle_flag;
    reg  [3:0] irq_mask;
    wire [3:0] live_output;
    wire [3:0] toggle_event;
    wire [3:0] cfg_nib [0:3];
    wire [3:0] cmp_on;
    wire [3:0] invert;
    wire [3:0] irq_allow;
    wire [3:0] choice;

    // A in high nibble of A/B
    assign cfg_nib[0] = comparator_ab_config[7:4];
    assign cfg_nib[1] = comparator_ab_config[3:0];
    assign cfg_nib[2] = comparator_cd_config[7:4];
    assign cfg_nib[3] = comparator_cd_config[3:0];

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : chan
            assign cmp_on[g]    = cfg_nib[g][`CFG_ON_BIT];
            assign choice[g]    = cfg_nib[g][`CFG_CHOICE_BIT];
            assign irq_allow[g] = cfg_nib[g][`CFG_IRQ_BIT];
            assign invert[g]    = cfg_nib[g][`CFG_INVERT_BIT];
            comparator_channel u_chan (
                .i_clk    (i_clk),
                .i_rstn   (i_rstn),
                .i_on     (cmp_on[g]),
                .i_invert (invert[g]),
                .i_raw    (i_cmp_raw[g]),
                .o_live   (live_output[g]),
                .o_toggle (toggle_event[g])
            );
        end
    endgenerate

    // APB decode; one wait state, pready and read data registered the clock after access
    wire [`ADDR_WIDTH-1:0] addr = i_paddr[`ADDR_WIDTH-1:0];
    wire       access   = i_psel & i_penable & ~o_pready;
    wire       hit_st   = (addr == `ADDR_STATUS_HYST);
    wire       hit_ab   = (addr == `ADDR_CFG_AB);
    wire       hit_cd   = (addr == `ADDR_CFG_CD);
    wire       hit_t0   = (addr == `ADDR_THRESH_FIRST);
    wire       hit_t1   = (addr == `ADDR_THRESH_SECOND);
    wire       hit_mk   = (addr == `ADDR_IRQ_MASK);
    wire       mapped   = hit_st | hit_ab | hit_cd | hit_t0 | hit_t1 | hit_mk;
    wire       wr       = access & i_pwrite & mapped;
    wire [3:0] flag_clr = (wr & hit_st) ? i_pwdata[7:4] : 4'h0;

    reg [7:0] read_mux;
    always @* begin
        case (1'b1)
            hit_st:  read_mux = {toggle_flag, live_output};
            hit_ab:  read_mux = comparator_ab_config;
            hit_cd:  read_mux = comparator_cd_config;
            hit_t0:  read_mux = o_first_threshold_level;
            hit_t1:  read_mux = o_second_threshold_level;
            hit_mk:  read_mux = {4'h0, irq_mask};
            default: read_mux = 8'h00;
        endcase
    end

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_prdata                 <= 32'h00000000;
            o_pready                 <= 1'b0;
            o_pslverr                <= 1'b0;
            comparator_ab_config     <= `RST_CFG;
            comparator_cd_config     <= `RST_CFG;
            o_first_threshold_level  <= `RST_THRESH;
            o_second_threshold_level <= `RST_THRESH;
            o_a_hysteresis_code      <= `RST_HYS;
            o_bcd_hysteresis_code    <= `RST_HYS;
            irq_mask                 <= `RST_MASK;
        end else begin
            o_pready  <= access;
            o_pslverr <= access & ~mapped;
            o_prdata  <= (access & ~i_pwrite) ? {24'h000000, read_mux} : 32'h00000000;
            if (wr) begin
                if (hit_ab)
                    comparator_ab_config <= i_pwdata[7:0];
                if (hit_cd)
                    comparator_cd_config <= i_pwdata[7:0];
                if (hit_t0)
                    o_first_threshold_level <= i_pwdata[7:0];
                if (hit_t1)
                    o_second_threshold_level <= i_pwdata[7:0];
                if (hit_mk)
                    irq_mask <= i_pwdata[3:0];
                if (hit_st) begin
                    o_bcd_hysteresis_code <= i_pwdata[`ST_BCD_HYS_LSB +: 2];
                    o_a_hysteresis_code   <= i_pwdata[`ST_A_HYS_LSB +: 2];
                end
            end
        end
    end

    // Note: pready is a registered pulse, so the access cycle is two clocks.
    // Gate that stops a second pulse while pready is still high is in access.

    always @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            toggle_flag         <= 4'h0;
            o_cmp_on            <= 4'h0;
            o_use_alt_threshold <= 4'h0;
            o_irq               <= 1'b0;
        end else begin
            toggle_flag <= (toggle_flag & ~flag_clr) | toggle_event;
            o_cmp_on    <= cmp_on;
            o_use_alt_threshold <= choice;
            o_irq <= |(toggle_flag & irq_allow & irq_mask);
        end
    end
endmodule

// >>> tb/comparator_control_monitor.sv
// Port checker for the comparator control block
`timescale 1ns/1ps
`include "comparator_control_map.vh"
module comparator_control_monitor (
    input wire        i_clk,
    input wire        i_rstn,
    input wire        i_psel,
    input wire        i_penable,
    input wire        i_pwrite,
    input wire [31:0] i_paddr,
    input wire [31:0] i_pwdata,
    input wire [31:0] o_prdata,
    input wire        o_pready,
    input wire        o_pslverr,
    input wire [3:0]  o_cmp_on,
    input wire [3:0]  o_use_alt_threshold,
    input wire [7:0]  o_first_threshold_level,
    input wire [1:0]  o_a_hysteresis_code,
    input wire [1:0]  o_bcd_hysteresis_code
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    wire [17:0] a  = i_paddr[17:0];
    wire        wr = o_pready & i_pwrite;
    wire [7:0]  d  = i_pwdata[7:0];
    wire [3:0]  sw = {d[3], d[7], d[2], d[6]};
    ready_answer_a: assert property (i_psel && i_penable && !o_pready |=> o_pready) else $error("late");
    ready_pulse_a: assert property (o_pready |=> !o_pready) else $error("held");
    bad_address_a: assert property (o_pready && a == 18'h280D4 |-> o_pslverr) else $error("slverr");
    first_code_a: assert property (wr && a == `ADDR_THRESH_FIRST |=>
        o_first_threshold_level == $past(d)) else $error("code");
    ab_fields_a: assert property (wr && a == `ADDR_CFG_AB |=>
        {o_cmp_on[1:0], o_use_alt_threshold[1:0]} == $past(sw)) else $error("ab");
    cd_fields_a: assert property (wr && a == `ADDR_CFG_CD |=>
        {o_cmp_on[3:2], o_use_alt_threshold[3:2]} == $past(sw)) else $error("cd");
    hyst_write_a: assert property (wr && a == `ADDR_STATUS_HYST |=>
        {o_bcd_hysteresis_code, o_a_hysteresis_code} == $past(d[3:0])) else $error("hys");
    live_gated_a: assert property (o_pready && !i_pwrite && a == `ADDR_STATUS_HYST |->
        (o_prdata[3:0] & ~o_cmp_on) == 4'h0) else $error("live");
endmodule
bind analog_comparator_control comparator_control_monitor i_comparator_control_monitor (.*);

// >>> tb/tb.sv
// Self-checking bench for the comparator control block
`timescale 1ns/1ps
`include "comparator_control_map.vh"
module tb;
    reg         i_clk, i_rstn, i_psel, i_penable, i_pwrite;
    reg  [31:0] i_paddr, i_pwdata, rd;
    reg  [3:0]  i_cmp_raw;
    wire [31:0] o_prdata;
    wire        o_pready, o_pslverr, o_irq;
    wire [3:0]  o_cmp_on, o_use_alt_threshold;
    wire [7:0]  o_first_threshold_level, o_second_threshold_level;
    wire [1:0]  o_a_hysteresis_code, o_bcd_hysteresis_code;
    integer     fails, check_count, n, k;
    // Unmapped word just past the mask register
    localparam [17:0] hole = 18'h280D4;
    analog_comparator_control i_analog_comparator_control (.*);
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    task report_and_stop;
        if (fails == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task cmp(input string nm, input [31:0] exp, input [31:0] got);
        check_count = check_count + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("BAD %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Request held until pready is sampled; data taken at that same edge
    task apb(input [17:0] ad, input w, input [7:0] d);
        @(posedge i_clk);
        {i_psel, i_pwrite, i_paddr, i_pwdata} <= {1'b1, w, 14'h0000, ad, 24'h000000, d};
        @(posedge i_clk);
        i_penable <= 1'b1;
        for (n = 0; n < 20 && o_pready !== 1'b1; n = n + 1)
            @(posedge i_clk);
        rd = o_prdata;
        cmp("slverr", ad == hole, o_pslverr);
        {i_psel, i_penable} <= 2'b00;
        fails = fails + (n == 20);
        if (n == 20)
            report_and_stop;
    endtask
    task rdc(input string nm, input [17:0] ad, input [7:0] e);
        apb(ad, 1'b0, 8'h00);
        cmp(nm, {24'h000000, e}, rd);
    endtask
    task reset_values;
        cmp("outputs", 32'h0, {o_cmp_on, o_use_alt_threshold, o_second_threshold_level, o_irq});
        rdc("cd", `ADDR_CFG_CD, 8'h00);
        rdc("mask", `ADDR_IRQ_MASK, 8'h0F);
    endtask
    task config_and_codes;
        apb(`ADDR_THRESH_FIRST, 1'b1, 8'hFF);
        apb(`ADDR_THRESH_SECOND, 1'b1, 8'h01);
        apb(`ADDR_CFG_AB, 1'b1, 8'h6A);
        apb(`ADDR_CFG_CD, 1'b1, 8'hC5);
        apb(hole, 1'b1, 8'h00);
        cmp("levels", 32'h0000FF01, {o_first_threshold_level, o_second_threshold_level});
        cmp("enables", 32'h6, o_cmp_on);
        cmp("choices", 32'hD, o_use_alt_threshold);
        for (k = 0; k < 4; k = k + 1) begin
            apb(`ADDR_STATUS_HYST, 1'b1, {4'h0, k[1:0], ~k[1:0]});
            cmp("hys", {k[1:0], ~k[1:0]}, {o_bcd_hysteresis_code, o_a_hysteresis_code});
        end
    endtask
    task toggle_events;
        apb(`ADDR_CFG_AB, 1'b1, 8'hAB);
        apb(`ADDR_CFG_CD, 1'b1, 8'hA0);
        // Bias settling wait after enabling
        repeat (`SETTLE_CYCLES) @(posedge i_clk);
        apb(`ADDR_STATUS_HYST, 1'b1, 8'hF0);
        rdc("idle", `ADDR_STATUS_HYST, 8'h02);
        i_cmp_raw <= 4'h9;
        repeat (7) @(posedge i_clk);
        cmp("irq", 32'h1, o_irq);
        rdc("rise", `ADDR_STATUS_HYST, 8'h13);
        i_cmp_raw <= 4'hB;
        repeat (7) @(posedge i_clk);
        rdc("fall", `ADDR_STATUS_HYST, 8'h31);
        apb(`ADDR_IRQ_MASK, 1'b1, 8'h00);
        @(posedge i_clk);
        cmp("masked", 32'h0, o_irq);
        apb(`ADDR_IRQ_MASK, 1'b1, 8'h0F);
        apb(`ADDR_STATUS_HYST, 1'b1, 8'h30);
        rdc("cleared", `ADDR_STATUS_HYST, 8'h01);
        apb(`ADDR_CFG_AB, 1'b1, 8'h8B);
        i_cmp_raw <= 4'hA;
        repeat (7) @(posedge i_clk);
        rdc("no allow", `ADDR_STATUS_HYST, 8'h10);
        cmp("no irq", 32'h0, o_irq);
        // Unused second threshold parked at zero
        apb(`ADDR_THRESH_SECOND, 1'b1, 8'h00);
        cmp("parked", 32'h0, o_second_threshold_level);
    endtask
    initial begin
        {i_rstn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata, i_cmp_raw} = 0;
        fails = 0;
        check_count = 0;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        reset_values;
        config_and_codes;
        toggle_events;
        report_and_stop;
    end
endmodule
